/* gma_core.sv */
// measurement posting, charge accumulation and programmable pin
`timescale 1ns/1ps
`include "gma_defines.svh"
module gma_core #(
   parameter int SAMP_CYC  = `GMA_T_SAMP_NS / `GMA_MCLK_NS,
   parameter int VOLT_CYC  = `GMA_T_VOLT_NS / `GMA_MCLK_NS,
   parameter int TEMP_CYC  = `GMA_T_TEMP_NS / `GMA_MCLK_NS,
   parameter int SLEEP_CYC = (`GMA_T_SLEEP_NS + `GMA_MCLK_NS - 1)
                             / `GMA_MCLK_NS,
   parameter int ACR_LSB   = `GMA_ACR_LSB
) (
   input  wire logic              mclk,        // 40 MHz clock
   input  wire logic              rst,         // sync reset, high
   input  wire gma_pkg::gma_samp_t cur_adc,    // sense pos minus neg
   input  wire gma_pkg::gma_vadc_t volt_adc,   // unsigned voltage code
   input  wire gma_pkg::gma_temp_t temp_adc,   // temperature code
   input  wire logic              snapshot_hold_bit_trig,   // snapshot trigger pulse
   input  wire logic              snapshot_hold_bit_clr,    // host clears hold bit
   input  wire logic              offset_blank_enable, // blanking on
   input  wire logic              sleep_mode,  // device asleep
   input  wire gma_pkg::gma_byte_t host_wdata, // host write byte
   input  wire logic              acr_msb_we,  // accumulator high byte
   input  wire logic              acr_lsb_we,  // accumulator low byte
   input  wire logic              bias_we,     // bias write
   input  wire logic              pio_we,      // pin control write
   input  wire logic              recall_acr,  // recall accumulator
   input  wire gma_pkg::gma_word_t ee_acr,     // stored accumulator
   input  wire gma_pkg::gma_byte_t ee_bias,    // stored bias
   output logic                   ee_acr_wr,   // backup pulse
   output gma_pkg::gma_word_t     ee_acr_data, // backup value
   input  wire logic              dq_in,       // serial data line
   input  wire logic              pio_in,      // pin level
   output logic                   pio_oe,      // pin driven low
   output logic                   pio_out,     // pin drive value
   output gma_pkg::gma_word_t     current_reg, // current result
   output gma_pkg::gma_word_t     avg_current, // average current
   output gma_pkg::gma_word_t     charge_accumulator, // accumulator
   output gma_pkg::gma_byte_t     bias,        // accumulation bias
   output gma_pkg::gma_volt_t     voltage_reg, // voltage result
   output gma_pkg::gma_temp_t     temp_reg,    // temperature result
   output logic                   snapshot_hold_bit, // hold active
   output logic                   prog_io_pin, // pin control bit
   output logic                   pio_level    // sensed pin level
);
   import gma_pkg::*;

   gma_pin_if dq_p ();
   gma_pin_if pio_p ();
   assign dq_p.raw  = dq_in;
   assign pio_p.raw = pio_in;

   gma_sync #(.RST_LVL(1'b1)) u_dq_sync (
      .mclk (mclk),
      .rst  (rst),
      .pin  (dq_p)
   );
   gma_sync #(.RST_LVL(1'b1)) u_pio_sync (
      .mclk (mclk),
      .rst  (rst),
      .pin  (pio_p)
   );

   function automatic gma_word_t clamp16(input logic signed [17:0] v);
      if (v > 18'sh07FFF)
         clamp16 = `GMA_CUR_MAX;
      else if (v < -18'sh08000)
         clamp16 = `GMA_CUR_MIN;
      else
         clamp16 = v[15:0];
   endfunction

   // timebase
   logic [31:0] samp_cnt, next_samp_cnt;
   logic [31:0] volt_cnt, next_volt_cnt;
   logic [31:0] temp_cnt, next_temp_cnt;
   logic [31:0] low_cnt,  next_low_cnt;
   logic        samp_tick, volt_tick, temp_tick, dq_long_low;

   always_comb begin
      samp_tick     = (samp_cnt == 32'(SAMP_CYC - 1));
      next_samp_cnt = samp_tick ? 32'h0 : samp_cnt + 32'h1;
      volt_tick     = (volt_cnt == 32'(VOLT_CYC - 1));
      next_volt_cnt = volt_tick ? 32'h0 : volt_cnt + 32'h1;
      temp_tick     = (temp_cnt == 32'(TEMP_CYC - 1));
      next_temp_cnt = temp_tick ? 32'h0 : temp_cnt + 32'h1;
      dq_long_low   = (low_cnt >= 32'(SLEEP_CYC));
      if (dq_p.level)
         next_low_cnt = 32'h0;
      else if (dq_long_low)
         next_low_cnt = low_cnt;
      else
         next_low_cnt = low_cnt + 32'h1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         samp_cnt <= 32'h0;
         volt_cnt <= 32'h0;
         temp_cnt <= 32'h0;
         low_cnt  <= 32'h0;
      end else begin
         samp_cnt <= next_samp_cnt;
         volt_cnt <= next_volt_cnt;
         temp_cnt <= next_temp_cnt;
         low_cnt  <= next_low_cnt;
      end
   end

   // current averaging and snapshot
   logic signed [24:0] cur_sum, next_cur_sum, cur_tot;
   logic signed [29:0] avg_sum, next_avg_sum, avg_tot;
   logic [6:0]         cur_n, next_cur_n;
   logic [11:0]        avg_n, next_avg_n;
   gma_word_t          next_current_reg, next_avg_current;
   logic               snapshot_hold_bit_wcur, next_snapshot_hold_bit_wcur;
   logic               snapshot_hold_bit_wvolt, next_snapshot_hold_bit_wvolt;
   logic               next_snapshot_hold_bit;
   gma_volt_t          next_voltage_reg;
   gma_temp_t          next_temp_reg;

   always_comb begin
      next_cur_sum     = cur_sum;
      next_avg_sum     = avg_sum;
      next_cur_n       = cur_n;
      next_avg_n       = avg_n;
      next_current_reg = current_reg;
      next_avg_current = avg_current;
      next_snapshot_hold_bit_wcur   = snapshot_hold_bit_wcur | snapshot_hold_bit_trig;
      next_snapshot_hold_bit_wvolt  = snapshot_hold_bit_wvolt | snapshot_hold_bit_trig;
      next_voltage_reg = voltage_reg;
      next_temp_reg    = temp_reg;
      // hold bit: a trigger in the clear cycle still wins
      next_snapshot_hold_bit = snapshot_hold_bit_trig | (snapshot_hold_bit & ~snapshot_hold_bit_clr);
      cur_tot = cur_sum + 25'(cur_adc);
      avg_tot = avg_sum + 30'(cur_adc);
      if (samp_tick) begin
         next_cur_n   = cur_n + 7'h1;
         next_cur_sum = (cur_n == 7'h7F) ? 25'sh0 : cur_tot;
         if (cur_n == 7'h7F && !snapshot_hold_bit)
            next_current_reg = clamp16(18'(cur_tot >>> `GMA_CUR_AVG_SH));
         if (snapshot_hold_bit_wcur) begin
            next_current_reg = clamp16(cur_adc);
            next_snapshot_hold_bit_wcur   = snapshot_hold_bit_trig;
         end
         next_avg_n   = avg_n + 12'h1;
         next_avg_sum = (avg_n == 12'hFFF) ? 30'sh0 : avg_tot;
         if (avg_n == 12'hFFF)
            next_avg_current = clamp16(18'(avg_tot >>> `GMA_AVG_AVG_SH));
      end
      if (volt_tick) begin
         if (!snapshot_hold_bit || snapshot_hold_bit_wvolt)
            next_voltage_reg = (volt_adc > 12'(`GMA_VOLT_MAX)) ?
                               `GMA_VOLT_MAX : volt_adc[10:0];
         if (snapshot_hold_bit_wvolt)
            next_snapshot_hold_bit_wvolt = snapshot_hold_bit_trig;
      end
      if (temp_tick)
         next_temp_reg = temp_adc;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_sum           <= 25'sh0;
         avg_sum           <= 30'sh0;
         cur_n             <= 7'h0;
         avg_n             <= 12'h0;
         current_reg       <= 16'h0;
         avg_current       <= 16'h0;
         snapshot_hold_bit_wcur         <= 1'b0;
         snapshot_hold_bit_wvolt        <= 1'b0;
         snapshot_hold_bit <= 1'b0;
         voltage_reg       <= 11'h0;
         temp_reg          <= 11'h0;
      end else begin
         cur_sum           <= next_cur_sum;
         avg_sum           <= next_avg_sum;
         cur_n             <= next_cur_n;
         avg_n             <= next_avg_n;
         current_reg       <= next_current_reg;
         avg_current       <= next_avg_current;
         snapshot_hold_bit_wcur         <= next_snapshot_hold_bit_wcur;
         snapshot_hold_bit_wvolt        <= next_snapshot_hold_bit_wvolt;
         snapshot_hold_bit <= next_snapshot_hold_bit;
         voltage_reg       <= next_voltage_reg;
         temp_reg          <= next_temp_reg;
      end
   end

   // charge accumulation
   logic signed [31:0] frac, next_frac, frac_sum;
   logic signed [18:0] biased;
   logic signed [16:0] moved;
   gma_word_t          next_acr, last_bk, next_last_bk, next_ee_data;
   gma_byte_t          acr_hi, next_acr_hi, next_bias;
   logic               init, sleep_d, next_ee_wr, blank;

   always_comb begin
      next_frac    = frac;
      next_acr     = charge_accumulator;
      next_last_bk = last_bk;
      next_acr_hi  = acr_hi;
      next_bias    = bias;
      next_ee_wr   = 1'b0;
      next_ee_data = ee_acr_data;
      biased = 19'(cur_adc) +
               (19'(signed'(bias)) <<< `GMA_BIAS_SH);
      blank = offset_blank_enable &&
              biased >= 19'(`GMA_BLANK_LO) &&
              biased <= 19'(`GMA_BLANK_HI);
      frac_sum = frac + 32'(biased);
      moved = 17'(signed'(charge_accumulator)) - 17'(signed'(last_bk));
      if (samp_tick && !blank) begin
         next_frac = frac_sum;
         // carry into the visible count, saturating
         if (frac_sum >= ACR_LSB) begin
            next_frac = frac_sum - ACR_LSB;
            if (charge_accumulator != `GMA_CUR_MAX)
               next_acr = charge_accumulator + 16'h1;
         end else if (frac_sum <= -ACR_LSB) begin
            next_frac = frac_sum + ACR_LSB;
            if (charge_accumulator != `GMA_CUR_MIN)
               next_acr = charge_accumulator - 16'h1;
         end
      end
      // backup after 100 uVh of movement
      if (moved >= `GMA_BACKUP_STEP || moved <= -`GMA_BACKUP_STEP) begin
         next_ee_wr   = 1'b1;
         next_ee_data = charge_accumulator;
         next_last_bk = charge_accumulator;
      end
      // high byte is staged until the low byte arrives
      if (acr_msb_we)
         next_acr_hi = host_wdata;
      if (acr_lsb_we) begin
         next_acr     = {acr_hi, host_wdata};
         next_frac    = 32'sh0;
         next_ee_wr   = 1'b1;
         next_ee_data = {acr_hi, host_wdata};
         next_last_bk = {acr_hi, host_wdata};
      end
      if (init || recall_acr) begin
         next_acr     = ee_acr;
         next_last_bk = ee_acr;
         next_frac    = 32'sh0;
         next_ee_wr   = 1'b0;
      end
      if (bias_we)
         next_bias = host_wdata;
      // reload bias at power-up and sleep exit
      if (init || (sleep_d && !sleep_mode))
         next_bias = ee_bias;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         frac               <= 32'sh0;
         charge_accumulator <= 16'h0;
         last_bk            <= 16'h0;
         acr_hi             <= 8'h0;
         bias               <= 8'h0;
         ee_acr_wr          <= 1'b0;
         ee_acr_data        <= 16'h0;
         init               <= 1'b1;
         sleep_d            <= 1'b0;
      end else begin
         frac               <= next_frac;
         charge_accumulator <= next_acr;
         last_bk            <= next_last_bk;
         acr_hi             <= next_acr_hi;
         bias               <= next_bias;
         ee_acr_wr          <= next_ee_wr;
         ee_acr_data        <= next_ee_data;
         init               <= 1'b0;
         sleep_d            <= sleep_mode;
      end
   end

   // programmable pin
   logic next_pio;

   always_comb begin
      next_pio = pio_we ? host_wdata[6] : prog_io_pin;
      if (sleep_mode || dq_long_low)
         next_pio = 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (rst)
         prog_io_pin <= `GMA_PIO_RST;
      else
         prog_io_pin <= next_pio;
   end

   // open-drain drive low when control is 0
   assign pio_oe  = ~prog_io_pin;
   assign pio_out = 1'b0;
   // sensed level for the feature register
   assign pio_level = pio_p.level;
endmodule

/* gma_defines.svh */
// constants for the gauge measurement accumulator
`ifndef GMA_DEFINES_SVH
`define GMA_DEFINES_SVH
`define GMA_MCLK_NS      25
`define GMA_T_SAMP_NS    687000
`define GMA_T_VOLT_NS    3400000
`define GMA_T_TEMP_NS    220000000
`define GMA_T_SLEEP_NS   2100000000
`define GMA_CUR_AVG_SH   7
`define GMA_AVG_AVG_SH   12
`define GMA_BIAS_SH      2
`define GMA_BLANK_LO     18'sh00020
`define GMA_BLANK_HI     18'sh00080
`define GMA_ACR_LSB      67074236
`define GMA_BACKUP_STEP  17'sh00010
`define GMA_CUR_MAX      16'h7FFF
`define GMA_CUR_MIN      16'h8000
`define GMA_VOLT_MAX     11'h3FF
`define GMA_PIO_RST      1'b1
`endif

/* gma_pkg.sv */
// shared types for the gauge measurement accumulator
package gma_pkg;
   typedef logic signed [17:0] gma_samp_t;
   typedef logic [15:0]        gma_word_t;
   typedef logic [7:0]         gma_byte_t;
   typedef logic [10:0]        gma_volt_t;
   typedef logic [11:0]        gma_vadc_t;
   typedef logic [10:0]        gma_temp_t;
endpackage

/* gma_pin_if.sv */
// carrier between the core and its pin conditioner
`timescale 1ns/1ps
interface gma_pin_if;
   logic raw;
   logic level;
   modport core (output raw, input level);
   modport cond (input raw, output level);
endinterface

/* gma_sync.sv */
// three-stage pin conditioner, level changes once stages two and three agree
`timescale 1ns/1ps
module gma_sync #(
   parameter logic RST_LVL = 1'b1
) (
   input  wire logic mclk,     // system clock
   input  wire logic rst,      // synchronous reset
   gma_pin_if.cond   pin       // raw in, clean level out
);
   logic s1;
   logic s2;
   logic s3;
   logic level;
   logic next_level;

   always_comb begin
      next_level = (s2 == s3) ? s3 : level;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1    <= RST_LVL;
         s2    <= RST_LVL;
         s3    <= RST_LVL;
         level <= RST_LVL;
      end else begin
         s1    <= pin.raw;
         s2    <= s1;
         s3    <= s2;
         level <= next_level;
      end
   end

   assign pin.level = level;
endmodule

/* gma_core_asserts.sv */
// concurrent checks on the accumulator core ports
`timescale 1ns/1ps
module gma_core_asserts (
   input wire logic               mclk,               // clock
   input wire logic               rst,                // sync reset
   input wire gma_pkg::gma_vadc_t volt_adc,           // voltage code
   input wire gma_pkg::gma_temp_t temp_adc,           // temperature code
   input wire logic               snapshot_hold_bit_trig,          // snapshot pulse
   input wire logic               snapshot_hold_bit_clr,           // hold clear
   input wire logic               sleep_mode,         // asleep
   input wire gma_pkg::gma_byte_t host_wdata,         // write byte
   input wire logic               acr_msb_we,         // high byte write
   input wire logic               acr_lsb_we,         // low byte write
   input wire logic               pio_we,             // pin write
   input wire logic               recall_acr,         // recall
   input wire logic               dq_in,              // data line
   input wire logic               ee_acr_wr,          // backup strobe
   input wire gma_pkg::gma_word_t ee_acr_data,        // backup value
   input wire logic               pio_oe,             // pin pulled low
   input wire logic               pio_out,            // drive value
   input wire gma_pkg::gma_word_t charge_accumulator, // accumulator
   input wire gma_pkg::gma_volt_t voltage_reg,        // voltage
   input wire gma_pkg::gma_temp_t temp_reg,           // temperature
   input wire logic               snapshot_hold_bit,  // hold
   input wire logic               prog_io_pin         // pin control
);
   import gma_pkg::*;
   logic [2:0] dq_hi;
   logic [2:0] next_dq_hi;
   gma_volt_t  volt_exp;
   logic       pio_bit;
   // a pin write only counts once the data line is long settled high
   always_comb begin
      next_dq_hi = dq_hi;
      if (rst || !dq_in) next_dq_hi = 3'h0;
      else if (dq_hi != 3'h7) next_dq_hi = dq_hi + 3'h1;
      volt_exp = (volt_adc > 12'h3FF) ? 11'h3FF : volt_adc[10:0];
      pio_bit = host_wdata[6];
   end
   always_ff @(posedge mclk) begin
      dq_hi <= next_dq_hi;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence acr_pair;
      acr_msb_we ##1 (acr_lsb_we && !recall_acr);
   endsequence
   chk_pin_drive: assert property (
      pio_oe == !prog_io_pin && pio_out == 1'h0)
      else $error("pin driver does not follow control bit");
   chk_pio_write: assert property (
      pio_we && !sleep_mode && dq_hi == 3'h7 |=> prog_io_pin == $past(pio_bit))
      else $error("pin control bit not written");
   chk_sleep_release: assert property (
      sleep_mode |=> prog_io_pin)
      else $error("pin not released in sleep");
   chk_snapshot_hold_bit_set: assert property (
      snapshot_hold_bit_trig |=> snapshot_hold_bit)
      else $error("hold bit not set by trigger");
   chk_snapshot_hold_bit_clear: assert property (
      snapshot_hold_bit_clr && !snapshot_hold_bit_trig |=> !snapshot_hold_bit)
      else $error("hold bit not cleared");
   chk_acr_write: assert property (
      acr_pair |=> charge_accumulator == {$past(host_wdata, 2), $past(host_wdata)})
      else $error("accumulator write value wrong");
   chk_acr_copy: assert property (
      acr_pair |=> ee_acr_wr && ee_acr_data == charge_accumulator)
      else $error("written accumulator not copied");
   chk_acr_nowrap: assert property (
      !acr_lsb_we && !recall_acr |=>
      !(charge_accumulator == 16'h8000 && $past(charge_accumulator) == 16'h7FFF)
      && !(charge_accumulator == 16'h7FFF && $past(charge_accumulator) == 16'h8000))
      else $error("accumulator wrapped");
   chk_volt_post: assert property (
      $changed(voltage_reg) |-> voltage_reg == $past(volt_exp))
      else $error("voltage result not clamped code");
   chk_temp_post: assert property (
      $changed(temp_reg) |-> temp_reg == $past(temp_adc))
      else $error("temperature result wrong");
   cov_snapshot_hold_bit: cover property (snapshot_hold_bit_trig ##1 snapshot_hold_bit);
   cov_backup: cover property (ee_acr_wr);
   cov_floor: cover property (charge_accumulator == 16'h8000);
endmodule
bind gma_core gma_core_asserts i_chk (.mclk, .rst, .volt_adc, .temp_adc,
   .snapshot_hold_bit_trig, .snapshot_hold_bit_clr, .sleep_mode, .host_wdata, .acr_msb_we, .acr_lsb_we,
   .pio_we, .recall_acr, .dq_in, .ee_acr_wr, .ee_acr_data, .pio_oe, .pio_out,
   .charge_accumulator, .voltage_reg, .temp_reg, .snapshot_hold_bit,
   .prog_io_pin);

/* gma_pack_model.sv */
// pack side: accumulator backup store and pulled-up pin
`timescale 1ns/1ps
module gma_pack_model #(
   parameter logic [15:0] EE_INIT = 16'h1234
) (
   input  wire logic               mclk,     // clock
   input  wire logic               ee_wr,    // store strobe
   input  wire gma_pkg::gma_word_t ee_din,   // value to store
   output gma_pkg::gma_word_t      ee_dout,  // stored value
   input  wire logic               pio_oe,   // device drives pin
   input  wire logic               pio_out,  // device drive value
   input  wire logic               ext_low,  // other logic pulls low
   output logic                    pio_wire  // resolved pin level
);
   import gma_pkg::*;
   initial ee_dout = EE_INIT;
   always @(posedge mclk) begin
      if (ee_wr) ee_dout <= ee_din;
   end
   // open drain, pull-up wins when nobody drives
   assign pio_wire = !((pio_oe && !pio_out) || ext_low);
endmodule

/* gma_core_tb.sv */
// self-checking bench for the accumulator core
`timescale 1ns/1ps
module gma_core_tb;
   import gma_pkg::*;
   logic       mclk = 1'h0;
   logic       rst = 1'h1;
   gma_samp_t  cur_adc = '0;
   gma_vadc_t  volt_adc = '0;
   gma_temp_t  temp_adc = '0;
   gma_byte_t  wd = '0;
   gma_byte_t  ee_bias = '0;
   logic [6:0] we = '0;
   logic       blank = 1'h0, sleep = 1'h0, dq = 1'h1, ext_low = 1'h0;
   logic       ee_wr, pin, oe, pout, hold, pctl, plev;
   gma_word_t  ee_acr, ee_dat, cur, avg, acc;
   gma_byte_t  bias;
   gma_volt_t  volt;
   gma_temp_t  temp;
   int         failures = 0;
   int         compares = 0;
   gma_samp_t  cin [4] = '{18'sh00123, 18'sh3FFFB, 18'sh1FFFF, 18'sh20000};
   gma_word_t  cexp [4] = '{16'h0123, 16'hFFFB, 16'h7FFF, 16'h8000};
   gma_samp_t  acur [3] = '{18'sh00040, 18'sh00040, 18'sh00020};
   logic       ablk [3] = '{1'h1, 1'h0, 1'h1};
   gma_byte_t  abias [3] = '{8'h00, 8'h00, 8'h40};
   gma_word_t  aexp [3] = '{16'h1000, 16'h1002, 16'h100B};
   always #12.5 mclk = ~mclk;
   gma_core #(.SAMP_CYC(8), .VOLT_CYC(20), .TEMP_CYC(50), .SLEEP_CYC(30),
      .ACR_LSB(1000)) i_dut (.mclk, .rst, .cur_adc, .volt_adc, .temp_adc,
      .snapshot_hold_bit_trig(we[4]), .snapshot_hold_bit_clr(we[5]), .offset_blank_enable(blank),
      .sleep_mode(sleep), .host_wdata(wd), .acr_msb_we(we[0]),
      .acr_lsb_we(we[1]), .bias_we(we[2]), .pio_we(we[3]),
      .recall_acr(we[6]), .ee_acr, .ee_bias, .ee_acr_wr(ee_wr),
      .ee_acr_data(ee_dat), .dq_in(dq), .pio_in(pin), .pio_oe(oe),
      .pio_out(pout), .current_reg(cur), .avg_current(avg),
      .charge_accumulator(acc), .bias, .voltage_reg(volt), .temp_reg(temp),
      .snapshot_hold_bit(hold), .prog_io_pin(pctl), .pio_level(plev));
   gma_pack_model i_pack (.mclk, .ee_wr, .ee_din(ee_dat), .ee_dout(ee_acr),
      .pio_oe(oe), .pio_out(pout), .ext_low, .pio_wire(pin));
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pulse(input int idx, input gma_byte_t d);
      @(posedge mclk);
      wd <= d;
      we[idx] <= 1'h1;
      @(posedge mclk);
      we <= '0;
   endtask
   // high byte goes first, low byte on the next edge
   task automatic acc_wr(input gma_word_t v);
      @(posedge mclk);
      wd <= v[15:8];
      we <= 7'h01;
      @(posedge mclk);
      wd <= v[7:0];
      we <= 7'h02;
      @(posedge mclk);
      we <= '0;
   endtask
   task automatic chk(input string nm, input gma_word_t e, input gma_word_t g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      w(3);
      chk("acc", 16'h1234, acc);
      chk("bias", 8'h00, bias);
      pulse(3, 8'h00);
      w(6);
      chk("pio_oe", 1'h1, oe);
      chk("pio_level", 1'h0, plev);
      pulse(3, 8'h40);
      w(6);
      chk("pio_level", 1'h1, plev);
      @(posedge mclk) ext_low <= 1'h1;
      w(6);
      chk("pio_level", 1'h0, plev);
      @(posedge mclk) ext_low <= 1'h0;
      pulse(3, 8'h00);
      @(posedge mclk) {sleep, ee_bias} <= {1'h1, 8'h05};
      w(3);
      chk("pio_ctl", 1'h1, pctl);
      @(posedge mclk) sleep <= 1'h0;
      w(3);
      chk("bias", 8'h05, bias);
      pulse(2, 8'hFB);
      w(1);
      chk("bias", 8'hFB, bias);
      pulse(3, 8'h00);
      @(posedge mclk) dq <= 1'h0;
      w(40);
      chk("pio_ctl", 1'h1, pctl);
      @(posedge mclk) {dq, ee_bias} <= {1'h1, 8'h00};
      pulse(2, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) cur_adc <= cin[i];
         w(2060);
         chk("current", cexp[i], cur);
      end
      @(posedge mclk) {volt_adc, temp_adc} <= {12'hFFF, 11'h0F8};
      w(60);
      chk("volt", 11'h3FF, volt);
      chk("temp", 11'h0F8, temp);
      @(posedge mclk) {cur_adc, volt_adc} <= {18'sh00040, 12'h100};
      w(2060);
      pulse(4, 8'h00);
      w(30);
      @(posedge mclk) {cur_adc, volt_adc} <= {18'sh00080, 12'h200};
      w(2060);
      chk("current", 16'h0040, cur);
      chk("volt", 11'h100, volt);
      pulse(5, 8'h00);
      w(2060);
      chk("current", 16'h0080, cur);
      chk("volt", 11'h200, volt);
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk) {cur_adc, blank} <= {acur[i], ablk[i]};
         pulse(2, abias[i]);
         acc_wr(16'h1000);
         w(324);
         chk("acc", aexp[i], acc);
      end
      @(posedge mclk) {rst, cur_adc, blank} <= {1'h1, 18'sh3FF00, 1'h0};
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      w(3);
      chk("acc", 16'h1000, acc);
      pulse(4, 8'h00);
      // three samples leave a fraction that the write must clear
      w(20);
      acc_wr(16'h8020);
      w(2);
      chk("ee", 16'h8020, ee_acr);
      w(322);
      chk("acc", 16'h8016, acc);
      pulse(6, 8'h00);
      w(1);
      chk("acc", 16'h8020, acc);
      w(33000);
      chk("acc", 16'h8000, acc);
      chk("ee", 16'h8000, ee_acr);
      chk("avg", 16'hFF00, avg);
      chk("hold", 1'h1, hold);
      end_sim;
   end
   initial begin
      repeat (70000) @(posedge mclk);
      failures++;
      end_sim;
   end
endmodule
